// file: rtl/ffoc_top.sv
// Purpose: Status flags and offset programming control for a 16384-word FIFO
// Assumes: WCLK and RCLK are slow pins sampled by CLK; memory array lives elsewhere
// Notes:   Offsets also readable over AXI4-Lite; mode bits fixed at master reset
// Behaviour
// - Almost-flag timing choice is captured during master reset and then held
// - Timing select high at master reset gives synchronous almost flags
// - Synchronous almost-full changes only on write clock edges
// - Synchronous almost-empty changes only on read clock edges
// - Timing select low at master reset gives asynchronous almost flags
// - Asynchronous almost-full falls on write edge, rises on read edge
// - Standard mode: half-full low while count exceeds half depth
// - Standard mode: almost-full low from depth minus full offset to full
// - Standard mode: full flag low at depth words, blocking writes
// - Standard mode: almost-empty high above empty offset; empty low at zero
// - Fall-through mode: half-full threshold moves up one word
// - Fall-through mode: almost-full one word later; input-ready high at depth plus one
// - Fall-through mode: almost-empty low to offset plus one; output-ready high at zero
// - Load low, write enable low: write clock steps four offset parts in
// - Load low, read enable low: read clock presents four offset parts out
// - Load low, serial enable low: one offset bit per write clock edge
// - Serial or parallel programming choice is fixed at master reset
// - Parallel read-back works in either programming choice
// - Offset programming is the same in both flag modes
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ffoc_top (
  input  wire logic                        CLK,
  input  wire logic                        RESET_N,
  input  wire logic                        WCLK,
  input  wire logic                        RCLK,
  input  wire logic                        WRITE_EN_N,
  input  wire logic                        READ_EN_N,
  input  wire logic                        OFFSET_LOAD_N,
  input  wire logic                        SERIAL_SHIFT_EN_N,
  input  wire logic                        MASTER_RESET_N,
  input  wire logic                        FLAG_TIMING_SELECT,
  input  wire logic [ffoc_pkg::DIN_W-1:0]  DATA_IN,
  output logic      [ffoc_pkg::DIN_W-1:0]  DATA_OUT,
  output logic                             FULL_FLAG_N,
  output logic                             EMPTY_FLAG_N,
  output logic                             HALF_FULL_N,
  output logic                             ALMOST_FULL_N,
  output logic                             ALMOST_EMPTY_N,
  input  wire logic [ffoc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                        S_AXI_AWVALID,
  output logic                             S_AXI_AWREADY,
  input  wire logic [31:0]                 S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output logic                             S_AXI_WREADY,
  output logic      [1:0]                  S_AXI_BRESP,
  output logic                             S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  input  wire logic [ffoc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                        S_AXI_ARVALID,
  output logic                             S_AXI_ARREADY,
  output logic      [31:0]                 S_AXI_RDATA,
  output logic      [1:0]                  S_AXI_RRESP,
  output logic                             S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic [ffoc_pkg::SYNC_W-1:0] pin_lvl;
  logic [ffoc_pkg::SYNC_W-1:0] pin_rise;

  ffoc_pin_sync u_sync (
    .CLK      (CLK),
    .RESET_N  (RESET_N),
    .pin_in   ({DATA_IN, FLAG_TIMING_SELECT, MASTER_RESET_N, SERIAL_SHIFT_EN_N,
                OFFSET_LOAD_N, READ_EN_N, WRITE_EN_N, RCLK, WCLK}),
    .pin_lvl  (pin_lvl),
    .pin_rise (pin_rise)
  );

  // Pin aliases after the synchroniser
  wire                       wclk_rise = pin_rise[ffoc_pkg::P_WCLK];
  wire                       rclk_rise = pin_rise[ffoc_pkg::P_RCLK];
  wire                       wen_n     = pin_lvl[ffoc_pkg::P_WEN];
  wire                       ren_n     = pin_lvl[ffoc_pkg::P_REN];
  wire                       load_n    = pin_lvl[ffoc_pkg::P_LOAD];
  wire                       sen_n     = pin_lvl[ffoc_pkg::P_SEN];
  wire                       mrs_act   = ~pin_lvl[ffoc_pkg::P_MRS];
  wire                       tsel      = pin_lvl[ffoc_pkg::P_TSEL];
  wire [ffoc_pkg::DIN_W-1:0] din       = pin_lvl[ffoc_pkg::P_DATA +: ffoc_pkg::DIN_W];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ffoc_pkg::ffoc_mode_t   mode_q;
  ffoc_pkg::ffoc_flags_t  flags_q;
  ffoc_pkg::ffoc_flags_t  flags_d;
  ffoc_pkg::ffoc_step_t   wstep_q;
  ffoc_pkg::ffoc_step_t   rstep_q;
  logic                   cfg_first_word_fallthrough_mode_q;
  logic [14:0]            cnt_q;
  logic [14:0]            cnt_d;
  logic [13:0]            eofs_q;
  logic [13:0]            fofs_q;
  logic [4:0]             ser_idx_q;
  logic [8:0]             dout_q;
  logic [8:0]             dout_d;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Capacity grows by the output register in fall-through mode
  wire [14:0] cap    = mode_q.first_word_fallthrough_mode ? ffoc_pkg::DEPTH_W + 15'h0001 : ffoc_pkg::DEPTH_W;
  wire [14:0] adj    = {14'h0000, mode_q.first_word_fallthrough_mode};
  wire        run    = ~mrs_act;
  wire        mem_wr = run & wclk_rise & load_n & ~wen_n & (cnt_q != cap);
  wire        mem_rd = run & rclk_rise & load_n & ~ren_n & (cnt_q != 15'h0000);
  wire        par_wr = run & wclk_rise & ~load_n & ~wen_n & ren_n & sen_n
                       & ~mode_q.serial;
  wire        par_rd = run & rclk_rise & ~load_n & wen_n & ~ren_n & sen_n;
  wire        ser_sh = run & wclk_rise & ~load_n & wen_n & ren_n & ~sen_n
                       & mode_q.serial;
  wire        ser_lo = ser_idx_q < ffoc_pkg::SER_FULL_LSB;
  wire [3:0]  ser_b  = ser_lo ? ser_idx_q[3:0] : 4'(ser_idx_q - ffoc_pkg::SER_FULL_LSB);

  // Word count, cleared by master reset; a write and a read together cancel
  always_comb begin
    cnt_d = cnt_q;
    if (mrs_act) begin
      cnt_d = 15'h0000;
    end else if (mem_wr && !mem_rd) begin
      cnt_d = cnt_q + 15'h0001;
    end else if (mem_rd && !mem_wr) begin
      cnt_d = cnt_q - 15'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Flag thresholds, evaluated on the count after this cycle's event
  // ----------------------------------------------------------------------
  wire full_c  = cnt_d == cap;
  wire empty_c = cnt_d == 15'h0000;
  wire half_c  = cnt_d > (ffoc_pkg::HALF_W + adj);
  wire af_c    = cnt_d >= (cap - {1'b0, fofs_q});
  wire ae_c    = cnt_d <= ({1'b0, eofs_q} + adj);

  // Sync mode samples only its own clock; async mode sets and clears on opposite clocks
  wire af_sync = wclk_rise ? ~af_c : flags_q.af_n;
  wire ae_sync = rclk_rise ? ~ae_c : flags_q.ae_n;
  wire af_asyn = (wclk_rise & af_c) ? 1'b0 :
                 (rclk_rise & ~af_c) ? 1'b1 : flags_q.af_n;
  wire ae_asyn = (rclk_rise & ae_c) ? 1'b0 :
                 (wclk_rise & ~ae_c) ? 1'b1 : flags_q.ae_n;

  // Standard pins use full/empty, fall-through pins use input-ready/output-ready
  always_comb begin
    flags_d.full_n  = mode_q.first_word_fallthrough_mode ? full_c : ~full_c;
    flags_d.empty_n = mode_q.first_word_fallthrough_mode ? empty_c : ~empty_c;
    flags_d.half_n  = ~half_c;
    flags_d.af_n    = mode_q.sync_tm ? af_sync : af_asyn;
    flags_d.ae_n    = mode_q.sync_tm ? ae_sync : ae_asyn;
    if (mrs_act) begin
      flags_d.af_n  = 1'b1;
      flags_d.ae_n  = 1'b0;
    end
  end

  // Offset part presented by a parallel read
  always_comb begin
    case (rstep_q)
      ffoc_pkg::FFOC_EMPTY_LO: dout_d = {1'b0, eofs_q[7:0]};
      ffoc_pkg::FFOC_EMPTY_HI: dout_d = {3'h0, eofs_q[13:8]};
      ffoc_pkg::FFOC_FULL_LO:  dout_d = {1'b0, fofs_q[7:0]};
      default:                 dout_d = {3'h0, fofs_q[13:8]};
    endcase
  end

  // ----------------------------------------------------------------------
  // Mode capture, count and flags
  // ----------------------------------------------------------------------
  // Modes follow the pins and the config bit only while master reset is held
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      mode_q <= ffoc_pkg::MODE_RST;
    end else if (mrs_act) begin
      mode_q <= '{first_word_fallthrough_mode: cfg_first_word_fallthrough_mode_q, sync_tm: tsel, serial: load_n};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cnt_q   <= 15'h0000;
      flags_q <= ffoc_pkg::FLAGS_RST;
    end else begin
      cnt_q   <= cnt_d;
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------------
  // Offset registers and programming pointers
  // ----------------------------------------------------------------------
  // Hazard: a bench mixing serial and parallel loads gets no warning; one is simply ignored
  always_ff @(posedge CLK) begin
    if (!RESET_N || mrs_act) begin
      eofs_q    <= ffoc_pkg::DEF_EMPTY_OF;
      fofs_q    <= ffoc_pkg::DEF_FULL_OF;
      wstep_q   <= ffoc_pkg::FFOC_EMPTY_LO;
      ser_idx_q <= 5'h00;
    end else if (par_wr) begin
      case (wstep_q)
        ffoc_pkg::FFOC_EMPTY_LO: eofs_q[7:0]  <= din[7:0];
        ffoc_pkg::FFOC_EMPTY_HI: eofs_q[13:8] <= din[5:0];
        ffoc_pkg::FFOC_FULL_LO:  fofs_q[7:0]  <= din[7:0];
        default:                 fofs_q[13:8] <= din[5:0];
      endcase
      wstep_q <= ffoc_pkg::ffoc_step_t'(wstep_q + 2'h1);
    end else if (ser_sh) begin
      if (ser_lo) begin
        eofs_q[ser_b] <= din[0];
      end else begin
        fofs_q[ser_b] <= din[0];
      end
      ser_idx_q <= (ser_idx_q == ffoc_pkg::SER_LAST) ? 5'h00 : ser_idx_q + 5'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N || mrs_act) begin
      rstep_q <= ffoc_pkg::FFOC_EMPTY_LO;
      dout_q  <= 9'h000;
    end else if (par_rd) begin
      rstep_q <= ffoc_pkg::ffoc_step_t'(rstep_q + 2'h1);
      dout_q  <= dout_d;
    end
  end

  assign DATA_OUT       = dout_q;
  assign FULL_FLAG_N    = flags_q.full_n;
  assign EMPTY_FLAG_N   = flags_q.empty_n;
  assign HALF_FULL_N    = flags_q.half_n;
  assign ALMOST_FULL_N  = flags_q.af_n;
  assign ALMOST_EMPTY_N = flags_q.ae_n;

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // Write fires once both halves are held and no response is pending
  wire        aw_ok   = S_AXI_AWVALID & awready_q;
  wire        w_ok    = S_AXI_WVALID & wready_q;
  wire        wr_go   = ~awready_q & ~wready_q & ~bvalid_q;
  wire        wr_cfg  = awaddr_q == ffoc_pkg::A_CONFIG;
  wire        ar_ok   = S_AXI_ARVALID & arready_q;
  wire [31:0] status  = {24'h000000, mode_q, flags_q};
  wire        rd_hit  = (S_AXI_ARADDR == ffoc_pkg::A_CONFIG) | (S_AXI_ARADDR == ffoc_pkg::A_STATUS)
                      | (S_AXI_ARADDR == ffoc_pkg::A_COUNT) | (S_AXI_ARADDR == ffoc_pkg::A_EMPTY_OF)
                      | (S_AXI_ARADDR == ffoc_pkg::A_FULL_OF);
  wire [31:0] rd_mux  = (S_AXI_ARADDR == ffoc_pkg::A_CONFIG)   ? {31'h0, cfg_first_word_fallthrough_mode_q} :
                        (S_AXI_ARADDR == ffoc_pkg::A_STATUS)   ? status :
                        (S_AXI_ARADDR == ffoc_pkg::A_COUNT)    ? {17'h00000, cnt_q} :
                        (S_AXI_ARADDR == ffoc_pkg::A_EMPTY_OF) ? {18'h00000, eofs_q} :
                        (S_AXI_ARADDR == ffoc_pkg::A_FULL_OF)  ? {18'h00000, fofs_q} : 32'h0;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= ffoc_pkg::RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      cfg_first_word_fallthrough_mode_q <= ffoc_pkg::CFG_RST;
    end else begin
      if (aw_ok) begin
        awaddr_q  <= S_AXI_AWADDR;
        awready_q <= 1'b0;
      end
      if (w_ok) begin
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_cfg ? ffoc_pkg::RESP_OKAY : ffoc_pkg::RESP_SLVERR;
        if (wr_cfg && wstrb_q[0]) begin
          cfg_first_word_fallthrough_mode_q <= wdata_q[ffoc_pkg::CFG_FIRST_WORD_FALLTHROUGH_MODE];
        end
      end
      if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Read answer follows the address by one cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= ffoc_pkg::RESP_OKAY;
    end else if (ar_ok) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= rd_hit ? ffoc_pkg::RESP_OKAY : ffoc_pkg::RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY  = wready_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N || mrs_act);

  mode_lock_a: assert property (##1 $stable(mode_q)) else $error("mode moved");
  af_sync_hold_a: assert property (mode_q.sync_tm && !wclk_rise |=> $stable(ALMOST_FULL_N))
    else $error("sync almost-full moved without write clock");
  ae_sync_hold_a: assert property (mode_q.sync_tm && !rclk_rise |=> $stable(ALMOST_EMPTY_N))
    else $error("sync almost-empty moved without read clock");
  af_async_set_a: assert property (!mode_q.sync_tm && wclk_rise && af_c |=> !ALMOST_FULL_N)
    else $error("async almost-full not set");
  ae_async_set_a: assert property (!mode_q.sync_tm && rclk_rise && ae_c |=> !ALMOST_EMPTY_N)
    else $error("async almost-empty not set");
  half_full_a: assert property (!mode_q.first_word_fallthrough_mode && cnt_q > ffoc_pkg::HALF_W |-> !HALF_FULL_N)
    else $error("half-full not low");
  full_flag_a: assert property (!mode_q.first_word_fallthrough_mode && cnt_q == ffoc_pkg::DEPTH_W
                                |-> !FULL_FLAG_N ##1 cnt_q <= ffoc_pkg::DEPTH_W)
    else $error("full flag or write block wrong");
  empty_flag_a: assert property (!mode_q.first_word_fallthrough_mode |-> EMPTY_FLAG_N == (cnt_q != 15'h0000))
    else $error("empty flag wrong");
  input_ready_a: assert property (mode_q.first_word_fallthrough_mode |-> FULL_FLAG_N == (cnt_q == cap))
    else $error("input-ready wrong");
  ser_step_a: assert property (ser_sh && ser_idx_q != ffoc_pkg::SER_LAST
                               |=> ser_idx_q == $past(ser_idx_q) + 5'h01)
    else $error("serial index stuck");
  par_lock_a: assert property (mode_q.serial && wclk_rise |=> $stable(wstep_q))
    else $error("parallel write in serial mode");

  full_cov_c:  cover property (!FULL_FLAG_N && !mode_q.first_word_fallthrough_mode);
  par_wr_c:    cover property (par_wr && wstep_q == ffoc_pkg::FFOC_FULL_HI);
  ser_end_c:   cover property (ser_sh && ser_idx_q == ffoc_pkg::SER_LAST);
  par_rd_c:    cover property (par_rd && mode_q.serial);

endmodule

// file: pkg/ffoc_pkg.sv
// Purpose: Shared constants and types for the FIFO flag and offset control block
// Assumes: Fixed depth of 16384 words, 14-bit offsets, 9-bit offset data path
// Notes:   Sync pin bit positions are shared by the top and its pin synchroniser
package ffoc_pkg;

  // ----------------------------------------------------------------------
  // Depth, counts and offsets
  // ----------------------------------------------------------------------
  localparam int            CNT_W        = 15;
  localparam int            OFS_W        = 14;
  localparam logic [14:0]   DEPTH_W      = 15'h4000;
  localparam logic [14:0]   HALF_W       = 15'h2000;
  localparam logic [13:0]   DEF_EMPTY_OF = 14'h007f;
  localparam logic [13:0]   DEF_FULL_OF  = 14'h007f;
  localparam logic [4:0]    SER_LAST     = 5'h1b;
  localparam logic [4:0]    SER_FULL_LSB = 5'h0e;
  localparam int            DIN_W        = 9;
  localparam int            LO_W         = 8;
  localparam int            HI_W         = 6;

  // ----------------------------------------------------------------------
  // Synchronised pin positions
  // ----------------------------------------------------------------------
  localparam int            P_WCLK   = 0;
  localparam int            P_RCLK   = 1;
  localparam int            P_WEN    = 2;
  localparam int            P_REN    = 3;
  localparam int            P_LOAD   = 4;
  localparam int            P_SEN    = 5;
  localparam int            P_MRS    = 6;
  localparam int            P_TSEL   = 7;
  localparam int            P_DATA   = 8;
  localparam int            SYNC_W   = 17;
  localparam logic [16:0]   SYNC_RST = 17'h000bf;

  // ----------------------------------------------------------------------
  // AXI4-Lite register map
  // ----------------------------------------------------------------------
  localparam int            ADDR_W      = 8;
  localparam logic [7:0]    A_CONFIG    = 8'h00;
  localparam logic [7:0]    A_STATUS    = 8'h04;
  localparam logic [7:0]    A_COUNT     = 8'h08;
  localparam logic [7:0]    A_EMPTY_OF  = 8'h0c;
  localparam logic [7:0]    A_FULL_OF   = 8'h10;
  localparam logic [1:0]    RESP_OKAY   = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;
  localparam int            CFG_FIRST_WORD_FALLTHROUGH_MODE    = 0;
  localparam logic          CFG_RST     = 1'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FFOC_EMPTY_LO = 2'b00,
    FFOC_EMPTY_HI = 2'b01,
    FFOC_FULL_LO  = 2'b10,
    FFOC_FULL_HI  = 2'b11
  } ffoc_step_t;

  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic half_n;
    logic af_n;
    logic ae_n;
  } ffoc_flags_t;

  typedef struct packed {
    logic first_word_fallthrough_mode;
    logic sync_tm;
    logic serial;
  } ffoc_mode_t;

  localparam ffoc_flags_t FLAGS_RST = 5'h16;
  localparam ffoc_mode_t  MODE_RST  = 3'h2;

endpackage

// file: rtl/ffoc_pin_sync.sv
// Purpose: Two-flop synchroniser plus rising-edge detect for every pin input
// Assumes: Pins change slowly against CLK (link clock 85 ns, CLK 5 ns)
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module ffoc_pin_sync (
  input  wire logic                        CLK,
  input  wire logic                        RESET_N,
  input  wire logic [ffoc_pkg::SYNC_W-1:0] pin_in,
  output logic      [ffoc_pkg::SYNC_W-1:0] pin_lvl,
  output logic      [ffoc_pkg::SYNC_W-1:0] pin_rise
);

  // ----------------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < ffoc_pkg::SYNC_W; i = i + 1) begin : g_bit
      logic meta_q;
      logic sync_q;
      logic prev_q;
      // Reset to SYNC_RST: clock bits high, master reset asserted, so no false edge shows at release
      always_ff @(posedge CLK) begin
        if (!RESET_N) begin
          meta_q <= ffoc_pkg::SYNC_RST[i];
          sync_q <= ffoc_pkg::SYNC_RST[i];
          prev_q <= ffoc_pkg::SYNC_RST[i];
        end else begin
          meta_q <= pin_in[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign pin_lvl[i]  = sync_q;
      assign pin_rise[i] = sync_q & ~prev_q;
    end
  endgenerate

endmodule

// file: verif/ffoc_host_model.sv
// Purpose: Write-side and read-side host logic driving the pin ports
// Assumes: One pin clock period is 17 CLK cycles (85 ns)
// Notes:   Pin clocks rest low between operations
`timescale 1ns/100ps
module ffoc_host_model (
  input  wire logic       CLK,
  output logic            wclk,
  output logic            rclk,
  output logic [3:0]      ctl,
  output logic [8:0]      din
);
  // Idle: no operation; controls are {load, wen, ren, sen}, all active low
  initial begin
    {wclk, rclk, ctl, din} = {2'b00, 4'hf, 9'h000};
  end
  // Control lines set outside an operation, so this model stays their only driver
  task automatic set_ctl(input logic [3:0] c);
    ctl <= c;
  endtask
  // One pin clock pulse; controls held 8 CLK either side of the rising edge
  task automatic op(input logic rd, input logic [3:0] c, input logic [8:0] d);
    @(posedge CLK);
    ctl <= c;
    din <= d;
    repeat (8) @(posedge CLK);
    if (rd) rclk <= 1'b1;
    else wclk <= 1'b1;
    repeat (8) @(posedge CLK);
    {wclk, rclk, ctl} <= {2'b00, 4'hf};
    din <= ~d; // Released lines must not keep showing old data
  endtask
endmodule

// file: verif/tb_fifo_flag_offset_control.sv
// Purpose: Self-checking bench for the FIFO flag and offset control block
// Assumes: Offsets programmed to 3 and 16381 so thresholds sit near empty
// Notes:   Half-full and full need 8k+ words and are left to the assertions
`timescale 1ns/100ps
module tb_fifo_flag_offset_control;
  logic        CLK, RESET_N, MASTER_RESET_N, FLAG_TIMING_SELECT, WCLK, RCLK;
  logic [3:0]  ctl;
  logic [8:0]  DATA_IN, DATA_OUT;
  logic        FULL_FLAG_N, EMPTY_FLAG_N, HALF_FULL_N, ALMOST_FULL_N, ALMOST_EMPTY_N;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  int          err_count, checked, cyc;
  logic [33:0] q;
  wire  [33:0] fl = {29'h0, FULL_FLAG_N, EMPTY_FLAG_N, HALF_FULL_N, ALMOST_FULL_N,
                     ALMOST_EMPTY_N};
  wire  [33:0] dq = {25'h0, DATA_OUT};

  ffoc_top dut (.CLK, .RESET_N, .WCLK, .RCLK, .WRITE_EN_N(ctl[2]), .READ_EN_N(ctl[1]),
    .OFFSET_LOAD_N(ctl[3]), .SERIAL_SHIFT_EN_N(ctl[0]), .MASTER_RESET_N, .FLAG_TIMING_SELECT,
    .DATA_IN, .DATA_OUT, .FULL_FLAG_N, .EMPTY_FLAG_N, .HALF_FULL_N, .ALMOST_FULL_N,
    .ALMOST_EMPTY_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY);
  ffoc_host_model host (.CLK, .wclk(WCLK), .rclk(RCLK), .ctl(ctl), .din(DATA_IN));

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One AXI4-Lite transfer; r gets {resp, data}
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [33:0] r);
    @(posedge CLK);
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} <= {a, a, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} <= {{3{w}}, {2{!w}}};
    forever begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_BREADY && S_AXI_BVALID) begin
        S_AXI_BREADY <= 1'b0;
        r = {S_AXI_BRESP, 32'h0};
        break;
      end
      if (S_AXI_RREADY && S_AXI_RVALID) begin
        S_AXI_RREADY <= 1'b0;
        r = {S_AXI_RRESP, S_AXI_RDATA};
        break;
      end
    end
  endtask
  task automatic mw(input int n); repeat (n) host.op(1'b0, 4'b1011, 9'h0); endtask
  task automatic mrd(input int n); repeat (n) host.op(1'b1, 4'b1101, 9'h0); endtask
  // Timing select flips and load returns high at release so a late change would show
  task automatic mreset(input logic t, input logic l);
    @(posedge CLK);
    {MASTER_RESET_N, FLAG_TIMING_SELECT} <= {1'b0, t};
    host.set_ctl({l, 3'h7});
    repeat (6) @(posedge CLK);
    {MASTER_RESET_N, FLAG_TIMING_SELECT} <= {1'b1, ~t};
    host.set_ctl(4'hf);
    repeat (16) @(posedge CLK);
  endtask
  task automatic prog();
    host.op(1'b0, 4'b0011, 9'h003);
    host.op(1'b0, 4'b0011, 9'h000);
    host.op(1'b0, 4'b0011, 9'h0fd);
    host.op(1'b0, 4'b0011, 9'h03f);
  endtask
  task automatic rdback(input int from);
    logic [8:0] p [4];
    p = '{9'h003, 9'h000, 9'h0fd, 9'h03f};
    for (int i = from; i < 4; i++) begin
      host.op(1'b1, 4'b0101, 9'h0);
      chk(dq, {25'h0, p[i]});
    end
  endtask
  task automatic t_par();
    mreset(1'b1, 1'b0);
    chk(fl, 34'h16);
    prog();
    rdback(0);
    axi(1'b0, ffoc_pkg::A_EMPTY_OF, 32'h0, q); chk(q, 34'h3);
    axi(1'b0, 8'h40, 32'h0, q); chk(q, 34'h200000000);
  endtask
  task automatic t_sync();
    mw(5); chk(fl, 34'h1c);
    mrd(1); chk(fl, 34'h1d);
    mrd(3); chk(fl, 34'h1c);
    mw(1); chk(fl, 34'h1e);
    mrd(2); chk(fl, 34'h16);
  endtask
  task automatic t_async();
    logic [27:0] v;
    v = {14'h3ffd, 14'h0003};
    mreset(1'b0, 1'b1);
    host.op(1'b0, 4'b0011, 9'h055);
    host.op(1'b1, 4'b0101, 9'h0); chk(dq, 34'h7f);
    for (int i = 0; i < 28; i++) host.op(1'b0, 4'b0110, {8'h0, v[i]});
    rdback(1);
    mw(5); chk(fl, 34'h1d);
    mrd(4); chk(fl, 34'h1e);
    mrd(1); chk(fl, 34'h16);
  endtask
  task automatic t_first_word_fallthrough_mode();
    axi(1'b1, ffoc_pkg::A_CONFIG, 32'h1, q); chk(q, 34'h0);
    axi(1'b1, ffoc_pkg::A_STATUS, 32'h1, q); chk(q, 34'h200000000);
    mreset(1'b0, 1'b0);
    chk(fl, 34'h0e);
    prog();
    rdback(0);
    mw(4); chk(fl, 34'h04);
    mw(1); chk(fl, 34'h05);
    mrd(5); chk(fl, 34'h0e);
  endtask
  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Clock, 5 ns period
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // Run about 1.5k cycles; the ceiling leaves ample margin for a hang
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    {RESET_N, MASTER_RESET_N, FLAG_TIMING_SELECT, S_AXI_WSTRB} = {3'b010, 4'hf};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    t_par();
    t_sync();
    t_async();
    t_first_word_fallthrough_mode();
    print_verdict();
  end
endmodule
